/* hdl/instr_timing_decoder.v */
`timescale 1ns/100ps
`include "instr_timing_defines.vh"
module instr_timing_decoder
(
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire        issue,
    input  wire [7:0]  opcode,
    input  wire [7:0]  operand1,
    input  wire [7:0]  operand2,
    input  wire [15:0] next_pc,
    input  wire [7:0]  acc,
    input  wire        carry,
    input  wire        bit_value,
    input  wire [7:0]  operand_value,
    input  wire [7:0]  program_status_word,
    input  wire [15:0] data_pointer16,
    input  wire [15:0] return_address,
    output wire        issue_ready,
    output wire        busy,
    output reg         done,
    output reg  [1:0]  instr_length,
    output reg  [3:0]  exec_cycles,
    output reg         branch_taken,
    output reg  [15:0] branch_target,
    output reg  [7:0]  direct_addr,
    output reg         direct_is_sfr,
    output reg  [7:0]  bank_register_addr,
    output reg  [7:0]  indirect_pointer_addr,
    output reg         clear_tested_bit,
    output reg         restore_priority,
    output reg         is_no_operation
);

    // ------------------------------------------------------------------------
    // Opcode classification
    // ------------------------------------------------------------------------
    reg  [1:0]  len_next;
    reg  [3:0]  cyc_next;
    reg  [3:0]  cond_next;
    reg  [2:0]  tgt_next;
    reg  [3:0]  count_reg;
    reg  [3:0]  count_next;
    wire        accept;

    always @*
    begin
        cond_next = `COND_NONE;
        tgt_next  = `TGT_NONE;
        // Columns 4..f each keep one timing pattern across most rows: 4 and 5, 6 and 7, and 8..f differ.
        case (opcode[3:0])
            4'h4:    begin len_next = `LEN_2; cyc_next = `CYC_2; end
            4'h5:    begin len_next = `LEN_2; cyc_next = `CYC_2; end
            4'h6,
            4'h7:    begin len_next = `LEN_1; cyc_next = `CYC_2; end
            default: begin len_next = `LEN_1; cyc_next = `CYC_1; end
        endcase
        if (opcode[4:0] == 5'h01)
        begin
            len_next = `LEN_2; cyc_next = `CYC_3; tgt_next = `TGT_PAGE;
        end
        else if (opcode[4:0] == 5'h11)
        begin
            len_next = `LEN_2; cyc_next = `CYC_3; tgt_next = `TGT_PAGE;
        end
        case (opcode)
            8'h00, 8'ha5: begin len_next = `LEN_1; cyc_next = `CYC_1; end
            8'h02, 8'h12: begin len_next = `LEN_3; cyc_next = `CYC_4; tgt_next = `TGT_LONG; end
            8'h22, 8'h32: begin len_next = `LEN_1; cyc_next = `CYC_5; tgt_next = `TGT_RET; end
            8'h03, 8'h13, 8'h23, 8'h33,
            8'hc4, 8'he4, 8'hf4, 8'h04,
            8'h14, 8'hd4, 8'ha3:
                begin len_next = `LEN_1; cyc_next = `CYC_1; end
            8'h10: begin len_next = `LEN_3; cyc_next = `CYC_3; cond_next = `COND_BITCLR; tgt_next = `TGT_REL2; end
            8'h20: begin len_next = `LEN_3; cyc_next = `CYC_3; cond_next = `COND_BIT;    tgt_next = `TGT_REL2; end
            8'h30: begin len_next = `LEN_3; cyc_next = `CYC_3; cond_next = `COND_NBIT;   tgt_next = `TGT_REL2; end
            8'h40: begin len_next = `LEN_2; cyc_next = `CYC_2; cond_next = `COND_CARRY;  tgt_next = `TGT_REL1; end
            8'h50: begin len_next = `LEN_2; cyc_next = `CYC_2; cond_next = `COND_NCARRY; tgt_next = `TGT_REL1; end
            8'h60: begin len_next = `LEN_2; cyc_next = `CYC_2; cond_next = `COND_ZERO;   tgt_next = `TGT_REL1; end
            8'h70: begin len_next = `LEN_2; cyc_next = `CYC_2; cond_next = `COND_NZERO;  tgt_next = `TGT_REL1; end
            8'h80: begin len_next = `LEN_2; cyc_next = `CYC_3; cond_next = `COND_ALWAYS; tgt_next = `TGT_REL1; end
            8'h73: begin len_next = `LEN_1; cyc_next = `CYC_3; cond_next = `COND_ALWAYS; tgt_next = `TGT_IND; end
            8'h42, 8'h52, 8'h62: begin len_next = `LEN_2; cyc_next = `CYC_2; end
            8'h43, 8'h53, 8'h63: begin len_next = `LEN_3; cyc_next = `CYC_3; end
            8'h72, 8'h82, 8'h92, 8'ha0, 8'ha2, 8'hb0, 8'hb2, 8'hc2, 8'hd2:
                begin len_next = `LEN_2; cyc_next = `CYC_2; end
            8'hb3, 8'hc3, 8'hd3: begin len_next = `LEN_1; cyc_next = `CYC_1; end
            8'h75, 8'h85: begin len_next = `LEN_3; cyc_next = `CYC_3; end
            8'h76, 8'h77, 8'h86, 8'h87, 8'ha6, 8'ha7:
                begin len_next = `LEN_2; cyc_next = `CYC_2; end
            8'h90: begin len_next = `LEN_3; cyc_next = `CYC_3; end
            8'h83, 8'h93: begin len_next = `LEN_1; cyc_next = `CYC_3; end
            8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3:
                begin len_next = `LEN_1; cyc_next = `CYC_3; end
            8'hc0, 8'hd0: begin len_next = `LEN_2; cyc_next = `CYC_2; end
            8'h84: begin len_next = `LEN_1; cyc_next = `CYC_8; end
            8'ha4: begin len_next = `LEN_1; cyc_next = `CYC_4; end
            8'hb4, 8'hb5: begin len_next = `LEN_3; cyc_next = `CYC_3; cond_next = `COND_CMP; tgt_next = `TGT_REL2; end
            8'hb6, 8'hb7: begin len_next = `LEN_3; cyc_next = `CYC_4; cond_next = `COND_CMP; tgt_next = `TGT_REL2; end
            8'hd5: begin len_next = `LEN_3; cyc_next = `CYC_3; cond_next = `COND_DEC; tgt_next = `TGT_REL2; end
            default:
            begin
                if (opcode[7:3] == 5'h0f || opcode[7:3] == 5'h15)
                begin
                    len_next = `LEN_2; cyc_next = `CYC_2; // Immediate or direct byte into a bank register.
                end
                else if (opcode[7:3] == 5'h11)
                begin
                    len_next = `LEN_2; cyc_next = `CYC_2;
                end
                else if (opcode[7:3] == 5'h17)
                begin
                    len_next = `LEN_3; cyc_next = `CYC_3; cond_next = `COND_CMP; tgt_next = `TGT_REL2;
                end
                else if (opcode[7:3] == 5'h1b)
                begin
                    len_next = `LEN_2; cyc_next = `CYC_2; cond_next = `COND_DEC; tgt_next = `TGT_REL1;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Branch resolution
    // ------------------------------------------------------------------------
    reg         taken_next;
    reg  [7:0]  cmp_left;
    reg  [7:0]  cmp_right;
    reg  [15:0] target_next;
    wire [15:0] rel1_target;
    wire [15:0] rel2_target;

    // The offset is signed, so it is sign-extended before the add.
    assign rel1_target = next_pc + {{8{operand1[`SIGN_BIT]}}, operand1};
    assign rel2_target = next_pc + {{8{operand2[`SIGN_BIT]}}, operand2};

    always @*
    begin
        cmp_left  = (opcode[3:0] == 4'h4 || opcode[3:0] == 4'h5) ? acc : operand_value;
        cmp_right = (opcode[3:0] == 4'h5) ? operand_value : operand1;
        case (cond_next)
            `COND_ALWAYS: taken_next = 1'b1;
            `COND_CARRY:  taken_next = carry;
            `COND_NCARRY: taken_next = ~carry;
            `COND_ZERO:   taken_next = (acc == `RESET_BYTE);
            `COND_NZERO:  taken_next = (acc != `RESET_BYTE);
            `COND_BIT,
            `COND_BITCLR: taken_next = bit_value;
            `COND_NBIT:   taken_next = ~bit_value;
            `COND_CMP:    taken_next = (cmp_left != cmp_right);
            `COND_DEC:    taken_next = (operand_value != `DEC_TO_ZERO);
            default:      taken_next = (tgt_next != `TGT_NONE);
        endcase
        case (tgt_next)
            `TGT_REL1: target_next = rel1_target;
            `TGT_REL2: target_next = rel2_target;
            `TGT_PAGE: target_next = {next_pc[`PAGE_HI_MSB:`PAGE_HI_LSB],
                                      opcode[`OPC_PAGE_MSB:`OPC_PAGE_LSB], operand1};
            `TGT_LONG: target_next = {operand1, operand2};
            `TGT_IND:  target_next = data_pointer16 + {8'h00, acc};
            `TGT_RET:  target_next = return_address;
            default:   target_next = next_pc;
        endcase
    end

    // ------------------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------------------
    // A new instruction is taken in the last cycle of the current one, so a
    // stream of back-to-back instructions keeps the pipeline full.
    assign issue_ready = (count_reg <= `CNT_LAST);
    assign busy        = (count_reg != `CNT_IDLE);
    assign accept      = issue & issue_ready;

    always @*
    begin
        if (accept)
        begin
            // Conditional forms are listed with their not-taken time.
            if (cond_next != `COND_NONE && cond_next != `COND_ALWAYS && taken_next)
                count_next = cyc_next + `CYC_TAKEN_EXTRA;
            else
                count_next = cyc_next;
        end
        else if (busy)
            count_next = count_reg - `CNT_LAST;
        else
            count_next = `CNT_IDLE;
    end

    // ------------------------------------------------------------------------
    // Registered results
    // ------------------------------------------------------------------------
    wire [7:0] bank_base;

    assign bank_base = {3'b000, program_status_word[`PSW_BANK_MSB:`PSW_BANK_LSB], 3'b000};

    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_reg             <= `CNT_IDLE;
            done                  <= 1'b0;
            instr_length          <= 2'd0;
            exec_cycles           <= `CNT_IDLE;
            branch_taken          <= 1'b0;
            branch_target         <= `RESET_ADDR;
            direct_addr           <= `RESET_BYTE;
            direct_is_sfr         <= 1'b0;
            bank_register_addr    <= `RESET_BYTE;
            indirect_pointer_addr <= `RESET_BYTE;
            clear_tested_bit      <= 1'b0;
            restore_priority      <= 1'b0;
            is_no_operation       <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            done      <= (count_reg == `CNT_LAST);
            if (accept)
            begin
                instr_length          <= len_next;
                exec_cycles           <= count_next;
                branch_taken          <= taken_next;
                branch_target         <= target_next;
                direct_addr           <= operand1;
                direct_is_sfr         <= operand1[`SFR_SELECT_BIT];
                bank_register_addr    <= bank_base | {5'b00000, opcode[2:0]};
                indirect_pointer_addr <= bank_base | {7'b0000000, opcode[0]};
                clear_tested_bit      <= (cond_next == `COND_BITCLR) & bit_value;
                restore_priority      <= (opcode == 8'h32);
                is_no_operation       <= (opcode == 8'h00) | (opcode == 8'ha5);
            end
        end
    end

endmodule

/* hdl/instr_timing_defines.vh */
`ifndef INSTR_TIMING_DEFINES_VH
`define INSTR_TIMING_DEFINES_VH

// ----------------------------------------------------------------------------
// Instruction length in bytes
// ----------------------------------------------------------------------------
`define LEN_1           2'd1
`define LEN_2           2'd2
`define LEN_3           2'd3

// ----------------------------------------------------------------------------
// Execution time in system clock cycles
// ----------------------------------------------------------------------------
`define CYC_1           4'd1
`define CYC_2           4'd2
`define CYC_3           4'd3
`define CYC_4           4'd4
`define CYC_5           4'd5
`define CYC_8           4'd8
`define CYC_TAKEN_EXTRA 4'd1
`define CNT_IDLE        4'd0
`define CNT_LAST        4'd1

// ----------------------------------------------------------------------------
// Branch condition kinds
// ----------------------------------------------------------------------------
`define COND_NONE       4'h0
`define COND_ALWAYS     4'h1
`define COND_CARRY      4'h2
`define COND_NCARRY     4'h3
`define COND_ZERO       4'h4
`define COND_NZERO      4'h5
`define COND_BIT        4'h6
`define COND_NBIT       4'h7
`define COND_BITCLR     4'h8
`define COND_CMP        4'h9
`define COND_DEC        4'ha

// ----------------------------------------------------------------------------
// Branch target forms
// ----------------------------------------------------------------------------
`define TGT_NONE        3'h0
`define TGT_REL1        3'h1
`define TGT_REL2        3'h2
`define TGT_PAGE        3'h3
`define TGT_LONG        3'h4
`define TGT_IND         3'h5
`define TGT_RET         3'h6

// ----------------------------------------------------------------------------
// Field positions and fixed values
// ----------------------------------------------------------------------------
`define PSW_BANK_LSB    3
`define PSW_BANK_MSB    4
`define SFR_SELECT_BIT  7
`define PAGE_HI_MSB     15
`define PAGE_HI_LSB     11
`define OPC_PAGE_MSB    7
`define OPC_PAGE_LSB    5
`define SIGN_BIT        7
`define DEC_TO_ZERO     8'h01
`define RESET_BYTE      8'h00
`define RESET_ADDR      16'h0000

`endif

/* tb/instr_timing_decoder_properties.sv */
`timescale 1ns/100ps
module instr_timing_decoder_properties
(
    input wire        sys_clk,
    input wire        rst_n,
    input wire        issue,
    input wire [7:0]  opcode,
    input wire [7:0]  operand1,
    input wire [15:0] next_pc,
    input wire        carry,
    input wire [7:0]  program_status_word,
    input wire        issue_ready,
    input wire        busy,
    input wire        done,
    input wire [1:0]  instr_length,
    input wire [3:0]  exec_cycles,
    input wire        branch_taken,
    input wire [15:0] branch_target,
    input wire [7:0]  direct_addr,
    input wire        direct_is_sfr,
    input wire [7:0]  bank_register_addr,
    input wire [7:0]  indirect_pointer_addr,
    input wire        restore_priority,
    input wire        is_no_operation
);
    wire       take = issue && issue_ready;
    reg  [7:0] bank_exp_reg;
    reg  [7:0] ind_exp_reg;
    // Register addresses are predicted from the bank bits at the accepting edge.
    always @(posedge sys_clk)
    begin
        bank_exp_reg <= {3'b000, program_status_word[4:3], opcode[2:0]};
        ind_exp_reg  <= {3'b000, program_status_word[4:3], 2'b00, opcode[0]};
    end
    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_xor_imm; take && opcode == 8'h63 |=> exec_cycles == 4'd3 && instr_length == 2'd3; endproperty
    a_xor_imm: assert property (p_xor_imm) else $error("xor immediate timing wrong");
    property p_acc_single; take && opcode == 8'hc4 ##1 !issue |-> busy && issue_ready ##1 !busy && done; endproperty
    a_acc_single: assert property (p_acc_single) else $error("single cycle op not finished in time");
    property p_ptr_load; take && opcode == 8'h90 |=> exec_cycles == 4'd3 && instr_length == 2'd3; endproperty
    a_ptr_load: assert property (p_ptr_load) else $error("pointer load timing wrong");
    property p_direct_space; take |=> direct_addr == $past(operand1) && direct_is_sfr == ($past(operand1) >= 8'h80);
    endproperty
    a_direct_space: assert property (p_direct_space) else $error("direct space select wrong");
    property p_bank_select; take |=> bank_register_addr == bank_exp_reg && indirect_pointer_addr == ind_exp_reg; endproperty
    a_bank_select: assert property (p_bank_select) else $error("bank register address wrong");
    property p_rel_target; take && opcode == 8'h80 |=> branch_target == $past(next_pc) + {{8{direct_addr[7]}}, direct_addr};
    endproperty
    a_rel_target: assert property (p_rel_target) else $error("relative target wrong");
    property p_carry_idle; take && opcode == 8'h40 && !carry |=> exec_cycles == 4'd2 && !branch_taken; endproperty
    a_carry_idle: assert property (p_carry_idle) else $error("untaken carry branch wrong");
    property p_carry_taken; take && opcode == 8'h40 && carry |=> exec_cycles == 4'd3 && branch_taken; endproperty
    a_carry_taken: assert property (p_carry_taken) else $error("taken carry branch wrong");
    property p_idle_op; take && (opcode == 8'h00 || opcode == 8'ha5) |=> is_no_operation && exec_cycles == 4'd1; endproperty
    a_idle_op: assert property (p_idle_op) else $error("idle opcode timing wrong");
    property p_intr_return; take && opcode == 8'h32 |=> restore_priority && exec_cycles == 4'd5; endproperty
    a_intr_return: assert property (p_intr_return) else $error("interrupt return wrong");
    cover property (take && opcode == 8'h40 && carry);
    cover property (done && busy);
    cover property (take && opcode == 8'hb6);
endmodule

/* tb/data_mem_model.sv */
`timescale 1ns/100ps
module data_mem_model
(
    input  wire [7:0] addr,
    output wire [7:0] rdata,
    output wire       rbit
);
    // Contents equal the address, so the bench can predict every operand from the address it picks.
    reg [7:0] mem [0:255];
    integer   k;
    initial
    begin
        for (k = 0; k < 256; k = k + 1)
            mem[k] = k[7:0];
    end
    assign rdata = mem[addr];
    assign rbit  = rdata[0];
endmodule

/* tb/cpu_instruction_timing_decoder_tb_top.sv */
`timescale 1ns/100ps
module cpu_instruction_timing_decoder_tb_top;
    logic        sys_clk, rst_n, issue, carry, bit_value;
    logic [7:0]  opcode, operand1, operand2, acc, operand_value, program_status_word, dm_addr;
    logic [15:0] next_pc, data_pointer16, return_address, n;
    wire         issue_ready, busy, done, branch_taken, direct_is_sfr, clear_tested_bit, restore_priority;
    wire         is_no_operation, dm_bit;
    wire  [1:0]  instr_length;
    wire  [3:0]  exec_cycles;
    wire  [7:0]  direct_addr, bank_register_addr, indirect_pointer_addr, dm_rdata;
    wire  [15:0] branch_target;
    integer      failures, total_checks, i;
    // Rows: opcode, expected length nibble, expected cycle nibble.
    logic [15:0] plain_tab [0:39] = '{16'h6333, 16'he411, 16'hf411, 16'h2311, 16'h3311, 16'h0311, 16'h1311,
        16'hc411, 16'he811, 16'he612, 16'he522, 16'h8533, 16'h7533, 16'h9033, 16'h9313, 16'h8313, 16'he213,
        16'hf213, 16'he013, 16'hf013, 16'hc022, 16'hd022, 16'hc811, 16'hc522, 16'hc612, 16'hd612, 16'hc311,
        16'hd311, 16'hb311, 16'hc222, 16'hd222, 16'hb222, 16'h8222, 16'hb022, 16'h7222, 16'ha022, 16'ha222,
        16'h9222, 16'h0011, 16'ha511};
    // Rows: opcode, operand1, acc, memory address, length/cycles, carry, taken, target.
    logic [63:0] branch_tab [0:33] = '{64'h40fe0000_2311_1232, 64'h40fe0000_2200_0000, 64'h50fe0000_2301_1232,
        64'h50fe0000_2210_0000, 64'h60fe0000_2301_1232, 64'h60fe0500_2200_0000, 64'h70fe0500_2301_1232,
        64'h70fe0000_2200_0000, 64'h20100001_3401_1232, 64'h20100000_3300_0000, 64'h30100000_3401_1232,
        64'h30100001_3300_0000, 64'h10100001_3401_1232, 64'h10100000_3300_0000, 64'hb5222222_3300_0000,
        64'hb5222223_3401_1232, 64'hb4101000_3300_0000, 64'hb4101100_3401_1232, 64'hb8070007_3300_0000,
        64'hb8070008_3401_1232, 64'hb6300030_3400_0000, 64'hb6310030_3501_1232, 64'hd8fe0001_2200_0000,
        64'hd8fe0002_2301_1232, 64'hd8fe0000_2301_1232, 64'hd5100001_3300_0000, 64'hd5100080_3401_1232,
        64'hf1340000_2301_1734, 64'h12ab0000_3401_abfe, 64'h02ab0000_3401_abfe, 64'h80050000_2301_1239,
        64'h73001000_1301_2010, 64'h22000000_1501_4567, 64'h32000000_1501_4567};
    instr_timing_decoder uut
    (
        .sys_clk(sys_clk), .rst_n(rst_n), .issue(issue), .opcode(opcode), .operand1(operand1),
        .operand2(operand2), .next_pc(next_pc), .acc(acc), .carry(carry), .bit_value(bit_value),
        .operand_value(operand_value), .program_status_word(program_status_word), .data_pointer16(data_pointer16),
        .return_address(return_address), .issue_ready(issue_ready), .busy(busy), .done(done),
        .instr_length(instr_length), .exec_cycles(exec_cycles), .branch_taken(branch_taken),
        .branch_target(branch_target), .direct_addr(direct_addr), .direct_is_sfr(direct_is_sfr),
        .bank_register_addr(bank_register_addr), .indirect_pointer_addr(indirect_pointer_addr),
        .clear_tested_bit(clear_tested_bit), .restore_priority(restore_priority), .is_no_operation(is_no_operation)
    );
    data_mem_model dmem (.addr(dm_addr), .rdata(dm_rdata), .rbit(dm_bit));
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task chk(input [15:0] seen, input [15:0] exp);
    begin
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    // Issues one instruction with operands from the memory model and counts its busy cycles into n.
    task run(input [7:0] op, input [7:0] o1, input [7:0] o2);
    begin
        @(posedge sys_clk);
        {issue, opcode, operand1, operand2} <= {1'b1, op, o1, o2};
        {operand_value, bit_value} <= {dm_rdata, dm_bit};
        @(posedge sys_clk);
        issue <= 1'b0;
        n = 16'h0000;
        #1;
        while (busy === 1'b1 && n < 16'h0010)
        begin
            n = n + 16'h0001;
            @(posedge sys_clk);
            #1;
        end
        chk({15'h0000, done}, 16'h0001);
    end
    endtask
    task t_plain;
    begin
        for (i = 0; i < 40; i = i + 1)
        begin
            run(plain_tab[i][15:8], 8'h00, 8'h00);
            chk({14'h0000, instr_length}, {12'h000, plain_tab[i][7:4]});
            chk(n, {12'h000, plain_tab[i][3:0]});
            chk({12'h000, exec_cycles}, {12'h000, plain_tab[i][3:0]});
        end
        $display("plain timing test done");
    end
    endtask
    task t_branch;
        logic [63:0] e;
    begin
        for (i = 0; i < 34; i = i + 1)
        begin
            e = branch_tab[i];
            @(posedge sys_clk);
            {acc, dm_addr, carry} <= {e[47:40], e[39:32], e[20]};
            run(e[63:56], e[55:48], 8'hfe);
            chk(n, {12'h000, e[27:24]});
            chk({14'h0000, instr_length}, {12'h000, e[31:28]});
            chk({15'h0000, branch_taken}, {15'h0000, e[16]});
            if (e[16])
                chk(branch_target, e[15:0]);
            chk({15'h0000, clear_tested_bit}, {15'h0000, e[16] && e[63:56] == 8'h10});
            chk({15'h0000, restore_priority}, {15'h0000, e[63:56] == 8'h32});
        end
        $display("branch test done");
    end
    endtask
    task t_addr;
    begin
        for (i = 0; i < 4; i = i + 1)
        begin
            @(posedge sys_clk);
            program_status_word <= {3'b111, i[1:0], 3'b111};
            run(8'he7, 8'h00, 8'h00);
            chk({8'h00, bank_register_addr}, {11'h000, i[1:0], 3'b111});
            chk({8'h00, indirect_pointer_addr}, {11'h000, i[1:0], 3'b001});
        end
        run(8'he5, 8'h7f, 8'h00);
        chk({7'h00, direct_is_sfr, direct_addr}, 16'h007f);
        run(8'he5, 8'h80, 8'h00);
        chk({7'h00, direct_is_sfr, direct_addr}, 16'h0180);
        $display("addressing test done");
    end
    endtask
    // Back-to-back issues, then a request held while a three-cycle instruction runs must wait.
    task t_overlap;
    begin
        @(posedge sys_clk);
        {issue, opcode} <= {1'b1, 8'h00};
        @(posedge sys_clk);
        opcode <= 8'ha5;
        @(posedge sys_clk);
        opcode <= 8'h63;
        #1;
        chk({13'h0000, busy, done, is_no_operation}, 16'h0007);
        @(posedge sys_clk);
        opcode <= 8'he4;
        #1;
        chk({11'h000, done, exec_cycles}, 16'h0013);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({12'h000, exec_cycles}, 16'h0003);
        @(posedge sys_clk);
        issue <= 1'b0;
        #1;
        chk({11'h000, done, exec_cycles}, 16'h0011);
        $display("overlap test done");
    end
    endtask
    task final_report;
    begin
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    initial
    begin
        {failures, total_checks, rst_n, issue, carry, bit_value} = 68'h0;
        {opcode, operand1, operand2, acc, operand_value, program_status_word, dm_addr} = 56'h0;
        {next_pc, data_pointer16, return_address} = {16'h1234, 16'h2000, 16'h4567};
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_plain;
        t_branch;
        t_addr;
        t_overlap;
        final_report;
    end
    // Roughly fifty times the expected run length.
    initial
    begin
        #2000000;
        failures = failures + 1;
        final_report;
    end
endmodule
bind instr_timing_decoder instr_timing_decoder_properties props
(
    .sys_clk(sys_clk), .rst_n(rst_n), .issue(issue), .opcode(opcode), .operand1(operand1), .next_pc(next_pc),
    .carry(carry), .program_status_word(program_status_word), .issue_ready(issue_ready), .busy(busy), .done(done),
    .instr_length(instr_length), .exec_cycles(exec_cycles), .branch_taken(branch_taken),
    .branch_target(branch_target), .direct_addr(direct_addr), .direct_is_sfr(direct_is_sfr),
    .bank_register_addr(bank_register_addr), .indirect_pointer_addr(indirect_pointer_addr),
    .restore_priority(restore_priority), .is_no_operation(is_no_operation)
);
